// ===== verilog/sdut_pkg.sv
// Constants shared by the simultaneous converter update block.
// Assumes a single 100 MHz board clock and a 4 KB target window.
package sdut_pkg;
  // Clock.
  localparam int CLK_PERIOD_NS = 10;

  // Channel store geometry.
  localparam int NUM_CH = 8;
  localparam int CODE_W = 16;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int BE_W   = 4;

  // Offsets inside the 4 KB window.
  localparam logic [11:0] OFS_START  = 12'h214;
  localparam logic [11:0] OFS_CH0    = 12'h220;
  localparam logic [11:0] CH_STRIDE  = 12'h004;
  localparam logic [15:0] START_CODE = 16'h0001;

  // Control word fields and codes.
  localparam int CTRL_W        = 16;
  localparam int TRIG_SEL_HI   = 6;
  localparam int TRIG_SEL_LO   = 5;
  localparam int TRIG_DIR_BIT  = 7;
  localparam logic [1:0] TRIG_SEL_SW_ONLY  = 2'h0;
  localparam logic [1:0] TRIG_SEL_EXT_ONLY = 2'h1;

  // Reset value of every channel: zero volts on bipolar ranges.
  localparam logic [15:0] CODE_RESET = 16'h0000;

  // Timing figures and their cycle counts.
  localparam int RETRIG_NS  = 6000;
  localparam int RETRIG_CYC = RETRIG_NS / CLK_PERIOD_NS;
  localparam int PULSE_NS   = 125;
  localparam int PULSE_CYC  = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACK_NS     = 150;
  localparam int ACK_CYC    = ACK_NS / CLK_PERIOD_NS;
  localparam int BUSY_NS    = 1000;
  localparam int BUSY_CYC   = BUSY_NS / CLK_PERIOD_NS;
  localparam int MAX_RATE_KHZ = 150;
  localparam int FULL_ACC_KHZ = 100;
  localparam int MIN_GAP_NS = (1000000 + MAX_RATE_KHZ - 1) / MAX_RATE_KHZ;
  localparam int MIN_GAP_CYC =
    (MIN_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 10;

  // Target port sequencing.
  typedef enum logic [1:0] {
    SDUT_BUS_IDLE,
    SDUT_BUS_ACK,
    SDUT_BUS_BUSY
  } sdut_bus_e;
endpackage

// ===== verilog/sdut_ext_trig.sv
// External trigger front end: synchroniser, falling edge and long-low repeat.
// Assumes the trigger pin is asynchronous and idles high.
`timescale 1ns/10ps
`default_nettype none
module sdut_ext_trig (
  // Clock and reset.
  input  wire logic i_clk,
  input  wire logic i_srst,
  // Control and pin.
  input  wire logic i_enable,
  input  wire logic i_trig_n,
  // Trigger event.
  output logic      o_fire
);
  logic                       sync_a;
  logic                       sync_b;
  logic                       prev;
  logic [sdut_pkg::CNT_W-1:0] low_cnt;
  logic                       fall;
  logic                       repeat_hit;

  // Three flops; only the second and the third are looked at by the edge and level logic.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      sync_a <= 1'b1;
      sync_b <= 1'b1;
      prev   <= 1'b1;
    end else begin
      sync_a <= i_trig_n;
      sync_b <= sync_a;
      prev   <= sync_b;
    end
  end

  assign fall = prev & ~sync_b;
  assign repeat_hit =
    (low_cnt == sdut_pkg::CNT_W'(sdut_pkg::RETRIG_CYC - 1));

  // Time the low level; a line held low too long fires again.
  always_ff @(posedge i_clk) begin
    if (i_srst || sync_b || fall || repeat_hit) begin
      low_cnt <= '0;
    end else begin
      low_cnt <= low_cnt + 1'b1;
    end
  end

  // Edge is seen three cycles after the pin, far inside the latency bound.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_fire <= 1'b0;
    end else begin
      o_fire <= i_enable & (fall | (repeat_hit & ~sync_b));
    end
  end
endmodule
`default_nettype wire

// ===== verilog/sdut_pulse_gen.sv
// Active-low trigger output pulse generator.
// Assumes the caller gates the pin with its own output enable.
`timescale 1ns/10ps
`default_nettype none
module sdut_pulse_gen (
  // Clock and reset.
  input  wire logic i_clk,
  input  wire logic i_srst,
  // Start of a pulse.
  input  wire logic i_start,
  // Pulse level, low while active.
  output logic      o_pulse_n
);
  logic [sdut_pkg::CNT_W-1:0] cnt;

  // A restart during a pulse stretches it rather than glitching high.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      cnt       <= '0;
      o_pulse_n <= 1'b1;
    end else if (i_start) begin
      cnt       <= sdut_pkg::CNT_W'(sdut_pkg::PULSE_CYC - 1);
      o_pulse_n <= 1'b0;
    end else if (cnt != '0) begin
      cnt <= cnt - 1'b1;
    end else begin
      o_pulse_n <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// ===== verilog/sdut_top.sv
// Control logic of an eight channel 16-bit analog output board: channel
// store, target port sequencing, trigger selection, pacing and pin drive.
// Assumes a simple single-beat target port, a static control word and
// converters that take a parallel code on each load pulse. The trigger
// pin is asynchronous; everything else is synchronous to i_clk.
// How it works
// - Eight 16-bit channel registers, each written on its own.
// - Codes are signed two's complement; the host encodes them.
// - Load channels first, then one trigger moves all to converters.
// - Reset clears channel registers and converter codes to zero volts.
// - After reset, updates keep giving zero until a channel is rewritten.
// - Enabled external falling edge starts conversion within 6.4 us once the pacing gap has run out.
// - Trigger low beyond 6 us fires another conversion.
// - As output, the trigger pin pulses low about 125 ns per start.
// - Conversions are paced to at most 150 kHz per channel.
// - All registers decode inside one 4 KB window.
// - Reads and writes of 32, 16 and 8 bits are accepted.
// - An accepted write completes about 150 ns after the request.
// - Control bits 6 and 5 select the trigger; 01 is external only.
// - Writing 0001h at offset 214h is the software trigger.
// - A new access while the previous is in progress gets a retry.
`timescale 1ns/10ps
`default_nettype none
module sdut_top (
  // Clock and reset.
  input  wire logic                          i_clk,
  input  wire logic                          i_srst,
  // Target port.
  input  wire logic                          i_req,
  input  wire logic                          i_wr,
  input  wire logic [sdut_pkg::ADDR_W-1:0]   i_addr,
  input  wire logic [sdut_pkg::DATA_W-1:0]   i_wdata,
  input  wire logic [sdut_pkg::BE_W-1:0]     i_be,
  output logic                               o_ack,
  output logic                               o_retry,
  output logic [sdut_pkg::DATA_W-1:0]        o_rdata,
  // Control word.
  input  wire logic [sdut_pkg::CTRL_W-1:0]   i_ctrl,
  // Trigger pin.
  input  wire logic                          i_trig_n,
  output logic                               o_trig_n,
  output logic                               o_trig_oe_n,
  // Converter side.
  output logic [sdut_pkg::NUM_CH-1:0][sdut_pkg::CODE_W-1:0] o_dac_code,
  output logic                               o_dac_load
);
  // Channel store and target port state.
  logic [sdut_pkg::NUM_CH-1:0][sdut_pkg::CODE_W-1:0] chan;
  sdut_pkg::sdut_bus_e                bus_state;
  sdut_pkg::sdut_bus_e                next_bus_state;
  logic [sdut_pkg::CNT_W-1:0]         bus_cnt;
  logic                               take;
  logic                               acc_wr;
  logic [sdut_pkg::ADDR_W-1:0]        acc_addr;
  logic                               ack_due;
  logic [3:0]                         wr_ch;
  logic [3:0]                         rd_ch;
  logic [sdut_pkg::DATA_W-1:0]        rd_word;

  // Trigger state.
  logic [1:0]                         trig_sel;
  logic                               trig_out_mode;
  logic                               ext_en;
  logic                               sw_en;
  logic                               ext_fire;
  logic                               sw_fire;
  logic                               pending;
  logic [sdut_pkg::CNT_W-1:0]         gap_cnt;
  logic                               launch;
  logic                               pulse_n;

  // Channel index hit by an address, or NUM_CH when none.
  function automatic logic [3:0] ch_of(
    input logic [sdut_pkg::ADDR_W-1:0] addr
  );
    logic [sdut_pkg::ADDR_W-1:0] rel;
    ch_of = 4'(sdut_pkg::NUM_CH);
    rel   = addr - sdut_pkg::OFS_CH0;
    if (addr >= sdut_pkg::OFS_CH0 &&
        rel < 12'(sdut_pkg::NUM_CH) * sdut_pkg::CH_STRIDE &&
        rel[1:0] == 2'h0) begin
      ch_of = 4'(rel[sdut_pkg::ADDR_W-1:2]);
    end
  endfunction

  // Merge enabled low bytes into a 16-bit value.
  function automatic logic [15:0] merge16(
    input logic [15:0] old,
    input logic [31:0] data,
    input logic [3:0]  be
  );
    merge16 = old;
    if (be[0]) begin
      merge16[7:0] = data[7:0];
    end
    if (be[1]) begin
      merge16[15:8] = data[15:8];
    end
  endfunction

  // Control word fields. The word is taken as static: a change of mode
  // while a pulse or a held start is in flight takes effect at once.
  assign trig_sel =
    i_ctrl[sdut_pkg::TRIG_SEL_HI:sdut_pkg::TRIG_SEL_LO];
  assign trig_out_mode = i_ctrl[sdut_pkg::TRIG_DIR_BIT];
  // Any nonzero selection turns the external input on outside output mode; 01 alone is
  // external only, so software starts are refused in that mode.
  assign ext_en = (trig_sel != sdut_pkg::TRIG_SEL_SW_ONLY) &
                  ~trig_out_mode;
  assign sw_en  = (trig_sel != sdut_pkg::TRIG_SEL_EXT_ONLY);

  // A request is taken only while the port is idle.
  assign take = i_req & (bus_state == sdut_pkg::SDUT_BUS_IDLE);

  // Last cycle of the ack phase; both the answer and the busy reload
  // key on it, so it is decoded once.
  assign ack_due = (bus_state == sdut_pkg::SDUT_BUS_ACK) &&
                   (bus_cnt == '0);

  // Channel hit by the incoming and by the captured address.
  assign wr_ch = ch_of(i_addr);
  assign rd_ch = ch_of(acc_addr);

  // Target port sequencing. A request taken at edge 0 moves the port to
  // the ack phase; the answer is sampled high at edge 15, which is the
  // 150 ns write latency. The busy phase then runs until edge 99, so
  // the port can take again at edge 100, after the 1000 ns internal write. Any request
  // in between is refused with retry and leaves no trace, which is why
  // the master may simply drop it and come back later.
  always_comb begin
    next_bus_state = bus_state;
    case (bus_state)
      sdut_pkg::SDUT_BUS_IDLE: begin
        if (i_req) begin
          next_bus_state = sdut_pkg::SDUT_BUS_ACK;
        end
      end
      sdut_pkg::SDUT_BUS_ACK: begin
        if (bus_cnt == '0) begin
          next_bus_state = sdut_pkg::SDUT_BUS_BUSY;
        end
      end
      sdut_pkg::SDUT_BUS_BUSY: begin
        if (bus_cnt == '0) begin
          next_bus_state = sdut_pkg::SDUT_BUS_IDLE;
        end
      end
      default: begin
        next_bus_state = sdut_pkg::SDUT_BUS_IDLE;
      end
    endcase
  end

  // State and the shared countdown for both phases.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      bus_state <= sdut_pkg::SDUT_BUS_IDLE;
      bus_cnt   <= '0;
    end else begin
      bus_state <= next_bus_state;
      if (take) begin
        bus_cnt <= sdut_pkg::CNT_W'(sdut_pkg::ACK_CYC - 2);
      end else if (ack_due) begin
        bus_cnt <= sdut_pkg::CNT_W'(sdut_pkg::BUSY_CYC -
                                    sdut_pkg::ACK_CYC - 1);
      end else if (bus_cnt != '0) begin
        bus_cnt <= bus_cnt - 1'b1;
      end
    end
  end

  // Capture the request; any address in the window is claimed.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      acc_wr   <= 1'b0;
      acc_addr <= '0;
    end else if (take) begin
      acc_wr   <= i_wr;
      acc_addr <= i_addr;
    end
  end

  // Retry is refused work: it shows in the same cycle, so the master
  // can release the port at once.
  assign o_retry = i_req & (bus_state != sdut_pkg::SDUT_BUS_IDLE);

  // Channel writes land at take; data is stored as signed code bits.
  // Only byte lanes 0 and 1 carry a channel, so wider writes simply
  // ignore lanes 2 and 3 and narrower ones merge into the old code.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      chan <= {sdut_pkg::NUM_CH{sdut_pkg::CODE_RESET}};
    end else if (take && i_wr && wr_ch != 4'(sdut_pkg::NUM_CH)) begin
      chan[wr_ch[2:0]] <=
        merge16(chan[wr_ch[2:0]], i_wdata, i_be);
    end
  end

  // Software start is a write of the start code at its offset.
  // The start code is judged on the merged low half, as for a channel.
  assign sw_fire = take && i_wr && i_addr == sdut_pkg::OFS_START &&
                   merge16(16'h0000, i_wdata, i_be) ==
                   sdut_pkg::START_CODE && sw_en;

  // Read word: channels sign-extended, start location and holes as zero.
  // Reads use the captured address, so a late master cannot move it.
  always_comb begin
    rd_word = '0;
    if (rd_ch != 4'(sdut_pkg::NUM_CH)) begin
      rd_word = {{(sdut_pkg::DATA_W - sdut_pkg::CODE_W)
                  {chan[rd_ch[2:0]][sdut_pkg::CODE_W-1]}},
                 chan[rd_ch[2:0]]};
    end
  end

  // Answer: a one-cycle ack at the end of the ack phase.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_ack <= 1'b0;
    end else begin
      o_ack <= ack_due;
    end
  end

  // Read data is held until the next read answer, so a slow master can
  // still pick it up after the ack pulse has gone.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_rdata <= '0;
    end else if (ack_due && !acc_wr) begin
      o_rdata <= rd_word;
    end
  end

  // External trigger front end; it only fires while the input is enabled.
  // Its edge logic runs even when disabled, so no stale edge is kept.
  sdut_ext_trig u_ext_trig (
    .i_clk    (i_clk),
    .i_srst   (i_srst),
    .i_enable (ext_en),
    .i_trig_n (i_trig_n),
    .o_fire   (ext_fire)
  );

  // Pacing: a trigger that comes too soon waits rather than being lost.
  // The cost is that such a start may come later than the external
  // latency bound when the previous start came less than about 0.3 us earlier.
  assign launch = (pending | ext_fire | sw_fire) & (gap_cnt == '0);

  // One held start; set wins, so a trigger in the launch cycle is kept.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      pending <= 1'b0;
    end else if (ext_fire || sw_fire) begin
      pending <= ~launch | pending;
    end else if (launch) begin
      pending <= 1'b0;
    end
  end

  // Gap counter: loads stay at least one 150 kHz period apart.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      gap_cnt <= '0;
    end else if (launch) begin
      gap_cnt <= sdut_pkg::CNT_W'(sdut_pkg::MIN_GAP_CYC - 1);
    end else if (gap_cnt != '0) begin
      gap_cnt <= gap_cnt - 1'b1;
    end
  end

  // All channels move together. During reset the load strobe is held
  // high with zero codes, so every converter is forced to zero volts
  // rather than keeping whatever it held before; the first edge after
  // release drops the strobe again.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_dac_code <= {sdut_pkg::NUM_CH{sdut_pkg::CODE_RESET}};
    end else if (launch) begin
      o_dac_code <= chan;
    end
  end

  // Load strobe: one cycle per launch.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_dac_load <= 1'b1;
    end else begin
      o_dac_load <= launch;
    end
  end

  // Trigger pin as an output marks each conversion start, so other
  // boards can follow this one. The pulse comes from a flop, never from
  // the launch decode, to keep glitches off a line that leaves the board.
  sdut_pulse_gen u_pulse_gen (
    .i_clk     (i_clk),
    .i_srst    (i_srst),
    .i_start   (launch & trig_out_mode),
    .o_pulse_n (pulse_n)
  );

  // The pin is driven only in output mode; in input mode the enable is
  // high and the external source owns the line.
  assign o_trig_n    = pulse_n;
  assign o_trig_oe_n = ~trig_out_mode;
endmodule
`default_nettype wire

// ===== test/sdut_props.sv
// Port timing checker for the simultaneous update block.
// Assumes it is bound to sdut_top and that the block has one clock.
`timescale 1ns/10ps
`default_nettype none
module sdut_props (
  // Clock and reset.
  input wire logic                         i_clk,
  input wire logic                         i_srst,
  // Watched ports.
  input wire logic                         i_req,
  input wire logic [sdut_pkg::CTRL_W-1:0]  i_ctrl,
  input wire logic                         i_trig_n,
  input wire logic                         o_ack,
  input wire logic                         o_retry,
  input wire logic                         o_trig_n,
  input wire logic [sdut_pkg::NUM_CH-1:0][sdut_pkg::CODE_W-1:0] o_dac_code,
  input wire logic                         o_dac_load
);
  logic        take;
  logic        rst_q;
  logic [6:0]  busy;
  logic [10:0] gap;

  // A request is taken exactly when it is not refused.
  assign take = i_req && !o_retry;

  // Busy span after each take; the retry level must cover it exactly.
  always_ff @(posedge i_clk) begin
    if (i_srst) busy <= 7'h00;
    else if (take) busy <= 7'h63;
    else if (busy != 7'h00) busy <= busy - 7'h01;
  end

  // Cycles since the last load; saturates so reset looks like a long gap.
  // The strobe held through reset is not a launch and is not counted.
  always_ff @(posedge i_clk) begin
    rst_q <= i_srst;
    if (i_srst) gap <= 11'h7ff;
    else if (o_dac_load && !rst_q) gap <= 11'h001;
    else if (gap != 11'h7ff) gap <= gap + 11'h001;
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);

  a_ack_latency: assert property (take |-> ##15 o_ack)
    else $error("ack missing 15 cycles after take");
  a_ack_cause: assert property (o_ack |-> $past(take, 15))
    else $error("ack without a take 15 cycles before");
  a_retry_span: assert property (i_req |-> o_retry == (busy != 7'h00))
    else $error("retry level disagrees with busy span");
  a_load_pace: assert property (o_dac_load |-> gap >= 11'h29b)
    else $error("loads closer than 667 cycles");
  a_code_hold: assert property ($changed(o_dac_code) |-> o_dac_load)
    else $error("codes changed without a load");
  a_reset_zero: assert property ($past(i_srst) |->
    o_dac_code == '0 && o_trig_n && !o_ack)
    else $error("outputs not cleared by reset");
  a_out_launch: assert property (o_dac_load && i_ctrl[7] |-> !o_trig_n)
    else $error("no output pulse at launch");
  a_pulse_width: assert property ($fell(o_trig_n) |->
    (!o_trig_n) [*8] ##1 (!o_trig_n) [*5] ##1 o_trig_n)
    else $error("output pulse not 13 cycles");
  a_ext_start: assert property (
    $fell(i_trig_n) && i_ctrl[6:5] != 2'h0 &&
    !i_ctrl[7] && gap >= 11'h2bc |-> ##1 !o_dac_load ##[2:4] o_dac_load)
    else $error("external fall not launched in time");

  // Main scenarios reached.
  c_write: cover property (take ##15 o_ack);
  c_retry: cover property (i_req && o_retry);
  c_ext: cover property ($fell(i_trig_n) ##[1:8] o_dac_load);
  c_out: cover property (o_dac_load && i_ctrl[7]);
endmodule

bind sdut_top sdut_props u_props (
  .i_clk(i_clk), .i_srst(i_srst), .i_req(i_req), .i_ctrl(i_ctrl),
  .i_trig_n(i_trig_n), .o_ack(o_ack), .o_retry(o_retry),
  .o_trig_n(o_trig_n), .o_dac_code(o_dac_code), .o_dac_load(o_dac_load));
`default_nettype wire

// ===== test/sdut_trig_src.sv
// Behavioural external trigger source for the update block.
// Assumes the bench commands each pulse; the line has a pull-up.
`timescale 1ns/10ps
`default_nettype none
module sdut_trig_src (
  // Clock.
  input  wire logic        i_clk,
  // Pulse command and its length in cycles.
  input  wire logic        i_go,
  input  wire logic [15:0] i_len,
  // Trigger line, active low.
  output logic             o_trig_n
);
  logic [15:0] left = 16'h0000;

  // Short requests are stretched to the 13 cycle minimum width.
  always_ff @(posedge i_clk) begin
    if (i_go) left <= (i_len < 16'h000d) ? 16'h000d : i_len;
    else if (left != 16'h0000) left <= left - 16'h0001;
  end

  // A released line rests high; long holds are only made on command.
  assign o_trig_n = (left == 16'h0000);
endmodule
`default_nettype wire

// ===== test/sdut_top_tb.sv
// Self-checking bench for the simultaneous update block.
// Assumes the trigger source model and the bound checker.
`timescale 1ns/10ps
`default_nettype none
module sdut_top_tb;
  logic             i_clk, i_srst, i_req, i_wr, go;
  logic             o_ack, o_retry, o_trig_n, o_trig_oe_n, o_dac_load;
  logic             src_n, pin_n;
  logic [11:0]      i_addr;
  logic [31:0]      i_wdata, o_rdata, rd;
  logic [3:0]       i_be;
  logic [15:0]      i_ctrl, len;
  logic [7:0][15:0] o_dac_code, shd, cur;
  int               bad_count, n_tests, loads, lows, l0;

  // The device drives the pin only while its enable is low.
  assign pin_n = o_trig_oe_n ? src_n : o_trig_n;

  sdut_top dut (.i_clk(i_clk), .i_srst(i_srst), .i_req(i_req), .i_wr(i_wr),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_be(i_be), .o_ack(o_ack),
    .o_retry(o_retry), .o_rdata(o_rdata), .i_ctrl(i_ctrl), .i_trig_n(pin_n),
    .o_trig_n(o_trig_n), .o_trig_oe_n(o_trig_oe_n),
    .o_dac_code(o_dac_code), .o_dac_load(o_dac_load));
  sdut_trig_src src (.i_clk(i_clk), .i_go(go), .i_len(len), .o_trig_n(src_n));

  // Free running 100 MHz clock.
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  // Counts loads and driven low cycles so tests judge totals.
  always @(posedge i_clk) begin
    if (o_dac_load && !i_srst) loads++;
    if (!o_trig_n && !i_srst) lows++;
  end

  task automatic chk(input logic [31:0] got, exp, input string msg);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic chk_codes(input logic [7:0][15:0] e);
    for (int i = 0; i < 8; i++) chk({16'h0, o_dac_code[i]}, {16'h0, e[i]},
      "code");
  endtask

  // One access; the request drops at the take edge, then the busy span runs.
  task automatic bus(input logic w, input logic [11:0] a,
                     input logic [31:0] d, input logic [3:0] be);
    int n;
    @(posedge i_clk);
    i_req <= 1'b1;
    i_wr <= w;
    i_addr <= a;
    i_wdata <= d;
    i_be <= be;
    @(posedge i_clk);
    i_req <= 1'b0;
    // An ack seen just after edge n-1 is sampled high at edge n.
    n = 1;
    do begin
      @(posedge i_clk);
      #1 n++;
    end while (!o_ack && n < 30);
    rd = o_rdata;
    chk(n, 15, "ack latency");
    repeat (85) @(posedge i_clk);
  endtask

  task automatic t_reset;
    l0 = loads;
    chk_codes(cur);
    chk({31'h0, o_trig_n}, 32'h1, "idle pin");
    bus(1'b1, 12'h214, 32'h1, 4'hf);
    chk(loads - l0, 1, "sw load");
    chk_codes(cur);
    $display("test reset done");
  endtask

  task automatic t_channels;
    for (int i = 0; i < 8; i++) begin
      shd[i] = 16'h7000 + 16'h1e11 * i[15:0];
      bus(1'b1, 12'h220 + 12'h004 * i[11:0], {16'hdead, shd[i]}, 4'hf);
    end
    bus(1'b1, 12'h234, 32'h55aa, 4'h1);
    shd[5][7:0] = 8'haa;
    bus(1'b1, 12'h300, 32'h1234, 4'hf);
    bus(1'b0, 12'h300, 32'h0, 4'hf);
    chk(rd, 32'h0, "unmapped read");
    for (int i = 0; i < 8; i++) begin
      bus(1'b0, 12'h220 + 12'h004 * i[11:0], 32'h0, 4'hf);
      chk(rd, {{16{shd[i][15]}}, shd[i]}, "read back");
    end
    chk_codes(cur);
    l0 = loads;
    bus(1'b1, 12'h214, 32'h2, 4'hf);
    chk(loads - l0, 0, "wrong start code");
    bus(1'b1, 12'h214, 32'h1, 4'hf);
    cur = shd;
    chk(loads - l0, 1, "start load");
    chk_codes(cur);
    $display("test channels done");
  endtask

  task automatic t_pace;
    repeat (700) @(posedge i_clk);
    l0 = loads;
    bus(1'b1, 12'h214, 32'h1, 4'hf);
    bus(1'b1, 12'h214, 32'h1, 4'hf);
    chk(loads - l0, 1, "second held back");
    repeat (500) @(posedge i_clk);
    chk(loads - l0, 2, "pending launched");
    $display("test pace done");
  endtask

  task automatic t_retry;
    @(posedge i_clk);
    i_req <= 1'b1;
    i_wr <= 1'b0;
    i_addr <= 12'h220;
    @(posedge i_clk);
    #1 chk({31'h0, o_retry}, 32'h1, "retry while busy");
    @(posedge i_clk);
    i_req <= 1'b0;
    repeat (110) @(posedge i_clk);
    bus(1'b0, 12'h224, 32'h0, 4'hf);
    chk(rd, {{16{shd[1][15]}}, shd[1]}, "read after retry");
    $display("test retry done");
  endtask

  task automatic pulse(input logic [15:0] n);
    @(posedge i_clk);
    go <= 1'b1;
    len <= n;
    @(posedge i_clk);
    go <= 1'b0;
  endtask

  task automatic t_ext;
    for (int m = 0; m < 4; m++) begin
      i_ctrl <= {9'h000, m[1:0], 5'h00};
      repeat (700) @(posedge i_clk);
      l0 = loads;
      pulse(16'h0014);
      repeat (10) @(posedge i_clk);
      chk(loads - l0, (m != 0) ? 1 : 0, "ext load");
    end
    i_ctrl <= 16'h0020;
    repeat (700) @(posedge i_clk);
    l0 = loads;
    bus(1'b1, 12'h214, 32'h1, 4'hf);
    chk(loads - l0, 0, "sw ignored in ext mode");
    pulse(16'h0320);
    repeat (790) @(posedge i_clk);
    chk(loads - l0, 2, "long low retriggers");
    $display("test ext done");
  endtask

  task automatic t_out;
    i_ctrl <= 16'h0080;
    repeat (700) @(posedge i_clk);
    chk({31'h0, o_trig_oe_n}, 32'h0, "pin driven");
    l0 = lows;
    bus(1'b1, 12'h214, 32'h1, 4'hf);
    chk(lows - l0, 13, "out pulse width");
    $display("test out done");
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Main sequence: reset for 12 cycles, then the tests in turn.
  initial begin
    {i_srst, i_req, i_wr, go} = 4'h8;
    {i_addr, i_wdata, i_be, i_ctrl, len} = '0;
    {shd, cur} = '0;
    repeat (12) @(posedge i_clk);
    i_srst <= 1'b0;
    // Let the load strobe held through reset drop before counting loads.
    repeat (2) @(posedge i_clk);
    t_reset;
    t_channels;
    t_pace;
    t_retry;
    t_ext;
    t_out;
    report_and_stop;
  end

  // Watchdog: the tests need about 9100 cycles.
  initial begin
    #300000;
    bad_count++;
    report_and_stop;
  end
endmodule
`default_nettype wire
